// [sad_pkg.sv]
// Functional notes
// - word add: signed 32-bit sum clamped to signed 32-bit range, written to destination
// - word add that clamps sets the sticky saturation flag
// - dual halfword add: two independent signed 16-bit adds, no carry between lanes
// - each halfword lane clamped to -32768..32767
// - low halfwords give result 15:0, high halfwords give result 31:16
// - quad byte add: four independent signed 8-bit adds, no carry across lanes
// - each byte lane clamped to -128..127 into its matching byte
// - byte lanes land at 7:0, 15:8, 23:16, 31:24 from same-position source bytes
// - without the signal-processing extension all three operations are undefined
package sad_pkg;
    localparam int SAD_DATA_W   = 32;
    localparam int SAD_HALF_W   = 16;
    localparam int SAD_BYTE_W   = 8;
    localparam int SAD_REG_IDX_W = 4;
    localparam logic [3:0] SAD_REG_SP = 4'hd;
    localparam logic [3:0] SAD_REG_PC = 4'hf;
    localparam logic SAD_FLAG_RST = 1'b0;

    // operation select, one-hot
    typedef enum logic [2:0] {
        SAD_OP_WORD = 3'b001,
        SAD_OP_HALF = 3'b010,
        SAD_OP_BYTE = 3'b100
    } sad_op_e;

    // one issued instruction
    typedef struct packed {
        sad_op_e                    op;
        logic [SAD_REG_IDX_W-1:0]   dst;
        logic [SAD_DATA_W-1:0]      src_first;
        logic [SAD_DATA_W-1:0]      src_second;
    } sad_req_s;

    // register file write-back
    typedef struct packed {
        logic [SAD_REG_IDX_W-1:0]   dst;
        logic [SAD_DATA_W-1:0]      data;
    } sad_wb_s;
endpackage

// [sad_datapath.sv]
`timescale 1ns/10ps
`default_nettype none
module sad_datapath
    import sad_pkg::*;
#(
    parameter bit EXT_PRESENT = 1'b1
) (
    // clock and reset
    input  wire logic     i_core_clk,
    input  wire logic     i_rst,
    // issue from the decoder
    input  wire logic     i_valid,
    input  wire logic     i_cond_pass,
    input  wire sad_req_s i_req,
    // write-back to the register file
    output logic          o_wb_valid,
    output sad_wb_s       o_wb,
    // decode outcome and status
    output logic          o_undefined,
    output logic          o_unpredictable,
    output logic          o_sat_flag
);
    localparam int NB = SAD_DATA_W / SAD_BYTE_W;
    localparam int NH = SAD_DATA_W / SAD_HALF_W;

    logic [SAD_DATA_W-1:0] a;
    logic [SAD_DATA_W-1:0] b;
    logic [SAD_DATA_W-1:0] byte_res;
    logic [SAD_DATA_W-1:0] half_res;
    logic [SAD_DATA_W-1:0] word_res;
    logic                  word_sat;
    logic [SAD_DATA_W:0]   word_sum;

    assign a = i_req.src_first;
    assign b = i_req.src_second;

    // byte lanes: each lane has its own 9-bit sum so no carry leaks across
    for (genvar g = 0; g < NB; g++) begin : g_byte
        logic [SAD_BYTE_W:0] s;
        assign s = {a[g*8+7], a[g*8 +: 8]} + {b[g*8+7], b[g*8 +: 8]};
        // two top bits differ means overflow; clamp toward the sign
        assign byte_res[g*8 +: 8] = (s[8] != s[7]) ? {s[8], {7{~s[8]}}} : s[7:0];
    end

    // halfword lanes, same scheme at 16 bits
    for (genvar g = 0; g < NH; g++) begin : g_half
        logic [SAD_HALF_W:0] s;
        assign s = {a[g*16+15], a[g*16 +: 16]} + {b[g*16+15], b[g*16 +: 16]};
        assign half_res[g*16 +: 16] = (s[16] != s[15]) ? {s[16], {15{~s[16]}}} : s[15:0];
    end

    // full word add with clamp
    assign word_sum = {a[31], a} + {b[31], b};
    assign word_sat = word_sum[32] != word_sum[31];
    assign word_res = word_sat ? {word_sum[32], {31{~word_sum[32]}}} : word_sum[31:0];

    logic       wb_valid_r, wb_valid_nxt;
    sad_wb_s    wb_r, wb_nxt;
    logic       undef_r, undef_nxt;
    logic       unpred_r, unpred_nxt;
    logic       sat_r, sat_nxt;
    logic       bad_reg;

    // stack pointer or program counter as destination is outside the contract; the
    // sources arrive as values only, so their indices cannot be screened here
    assign bad_reg = (i_req.dst == SAD_REG_SP) || (i_req.dst == SAD_REG_PC);

    // next-state: result select, undefined trap, sticky flag
    always_comb begin
        wb_valid_nxt = 1'b0;
        wb_nxt       = '{dst: i_req.dst, data: '0};
        undef_nxt    = 1'b0;
        unpred_nxt   = 1'b0;
        sat_nxt      = sat_r;
        if (i_valid && i_cond_pass) begin
            if (!EXT_PRESENT) begin
                undef_nxt = 1'b1;
            end else begin
                wb_valid_nxt = 1'b1;
                unpred_nxt   = bad_reg;
                case (i_req.op)
                    SAD_OP_WORD: begin
                        wb_nxt.data = word_res;
                        sat_nxt     = sat_r | word_sat; // only ever sets
                    end
                    SAD_OP_HALF: wb_nxt.data = half_res;
                    SAD_OP_BYTE: wb_nxt.data = byte_res;
                    default:     wb_valid_nxt = 1'b0;
                endcase
            end
        end
    end

    // registers; the flag only resets, no add clears it
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            wb_valid_r <= 1'b0;
            wb_r       <= '0;
            undef_r    <= 1'b0;
            unpred_r   <= 1'b0;
            sat_r      <= SAD_FLAG_RST;
        end else begin
            wb_valid_r <= wb_valid_nxt;
            wb_r       <= wb_nxt;
            undef_r    <= undef_nxt;
            unpred_r   <= unpred_nxt;
            sat_r      <= sat_nxt;
        end
    end

    assign o_wb_valid      = wb_valid_r;
    assign o_wb            = wb_r;
    assign o_undefined     = undef_r;
    assign o_unpredictable = unpred_r;
    assign o_sat_flag      = sat_r;

    // reference for the checks: each lane is sign-extended into a wide integer and
    // clamped by comparison, so it shares no adder or overflow logic with the lanes
    // above and a wrong clamp there cannot hide behind the same mistake here
    function automatic logic [SAD_DATA_W-1:0] ref_clamp(input longint sum,
                                                        input int     w);
        longint hi;
        longint lo;
        longint c;
        hi = (longint'(1) <<< (w - 1)) - 1;
        lo = -(longint'(1) <<< (w - 1));
        c  = sum;
        if (c > hi) begin
            c = hi;
        end else if (c < lo) begin
            c = lo;
        end
        return SAD_DATA_W'(c & ((longint'(1) <<< w) - 1));
    endfunction

    // reference add of w-bit signed lanes, each lane clamped on its own
    function automatic logic [SAD_DATA_W-1:0] ref_lanes(input logic [SAD_DATA_W-1:0] x,
                                                        input logic [SAD_DATA_W-1:0] y,
                                                        input int                    w);
        logic [SAD_DATA_W-1:0] r;
        longint                sx;
        longint                sy;
        r = '0;
        for (int k = 0; k < SAD_DATA_W / w; k++) begin
            // move the lane to the top, then shift it down with its sign
            sx = longint'($signed(x << (SAD_DATA_W - w * (k + 1)))) >>> (SAD_DATA_W - w);
            sy = longint'($signed(y << (SAD_DATA_W - w * (k + 1)))) >>> (SAD_DATA_W - w);
            r  = r | (ref_clamp(sx + sy, w) << (w * k));
        end
        return r;
    endfunction

    logic [SAD_DATA_W-1:0] ref_word;
    logic [SAD_DATA_W-1:0] ref_half;
    logic [SAD_DATA_W-1:0] ref_byte;
    logic                  ref_word_ovf;
    logic                  any_issue;
    logic                  word_issue;
    logic                  word_ovf_issue;

    // reference results for the current issue, one per operation
    assign ref_word       = ref_lanes(a, b, SAD_DATA_W);
    assign ref_half       = ref_lanes(a, b, SAD_HALF_W);
    assign ref_byte       = ref_lanes(a, b, SAD_BYTE_W);
    // the word add clamped when the wide sum differs from its clamped value
    assign ref_word_ovf   = (longint'($signed(a)) + longint'($signed(b)))
                         != longint'($signed(ref_word));
    // executed issues, as the checks see them
    assign any_issue      = i_valid && i_cond_pass && EXT_PRESENT;
    assign word_issue     = any_issue && (i_req.op == SAD_OP_WORD);
    assign word_ovf_issue = word_issue && ref_word_ovf;

    // one executed add of the given kind
    sequence s_issue(sad_op_e o);
        i_valid && i_cond_pass && EXT_PRESENT && i_req.op == o;
    endsequence

    // an executed add naming the stack pointer or program counter as destination
    sequence s_bad_dst;
        any_issue && (i_req.dst == SAD_REG_SP || i_req.dst == SAD_REG_PC);
    endsequence

    // an executed add with a legal destination
    sequence s_good_dst;
        any_issue && i_req.dst != SAD_REG_SP && i_req.dst != SAD_REG_PC;
    endsequence

    // an issue whose condition failed
    sequence s_cond_fail;
        i_valid && !i_cond_pass;
    endsequence

    chk_word_clamp: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_issue(SAD_OP_WORD) |=> o_wb_valid && o_wb.data == $past(ref_word))
        else $error("word add result wrong");
    chk_word_dst: assert property (@(posedge i_core_clk) disable iff (i_rst)
        any_issue |=> o_wb.dst == $past(i_req.dst))
        else $error("write-back destination wrong");
    chk_sat_set: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_issue(SAD_OP_WORD) ##0 ref_word_ovf |=> o_sat_flag)
        else $error("sticky flag not set");
    chk_sat_cause: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $rose(o_sat_flag) |-> $past(word_ovf_issue))
        else $error("sticky flag set without a word clamp");
    chk_flag_sticky: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_sat_flag |=> o_sat_flag)
        else $error("sticky flag cleared");
    chk_lane_flag: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (s_issue(SAD_OP_HALF) or s_issue(SAD_OP_BYTE)) |=> $stable(o_sat_flag))
        else $error("lane add touched flag");
    chk_cond_fail: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_cond_fail |=> !o_wb_valid && !o_undefined && $stable(o_sat_flag))
        else $error("failed condition changed state");
    chk_half_lanes: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_issue(SAD_OP_HALF) |=> o_wb_valid && o_wb.data == $past(ref_half))
        else $error("halfword lanes wrong");
    chk_half_low: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_issue(SAD_OP_HALF) ##0 (a[15] != b[15]) |=>
        o_wb.data[15:0] == $past(a[15:0]) + $past(b[15:0]))
        else $error("halfword low lane wrong");
    chk_half_range: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_issue(SAD_OP_HALF) ##0 (a[31] && b[31]) |=> o_wb.data[31])
        else $error("halfword clamp wrong");
    chk_byte_lanes: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_issue(SAD_OP_BYTE) |=> o_wb_valid && o_wb.data == $past(ref_byte))
        else $error("byte lanes wrong");
    chk_byte_top: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_issue(SAD_OP_BYTE) ##0 (a[31:24] == 8'h7f && !b[31]) |=> o_wb.data[31:24] == 8'h7f)
        else $error("byte clamp wrong");
    chk_byte_lane: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_issue(SAD_OP_BYTE) ##0 (a[7] != b[7]) |=> o_wb.data[7:0] == $past(a[7:0]) + $past(b[7:0]))
        else $error("byte lane wrong");
    chk_undef_trap: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_valid && i_cond_pass && !EXT_PRESENT |=> o_undefined && !o_wb_valid)
        else $error("undefined not raised");
    chk_undef_quiet: assert property (@(posedge i_core_clk) disable iff (i_rst)
        any_issue |=> !o_undefined)
        else $error("undefined raised with extension present");
    chk_unpred_dst: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_bad_dst |=> o_unpredictable)
        else $error("unpredictable not raised");
    chk_unpred_quiet: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_good_dst |=> !o_unpredictable)
        else $error("unpredictable raised for a legal destination");
endmodule
`default_nettype wire

// [sad_rf_model.sv]
`timescale 1ns/10ps
`default_nettype none
// register file on the far side of the datapath
module sad_rf_model
    import sad_pkg::*;
(
    // clock
    input  wire logic    i_core_clk,
    // write-back from the datapath
    input  wire logic    i_wb_valid,
    input  wire sad_wb_s i_wb
);
    logic [SAD_DATA_W-1:0] regs_r [16];

    // the entry changes one edge after the pulse, like the real file
    always_ff @(posedge i_core_clk) begin
        if (i_wb_valid) begin
            regs_r[i_wb.dst] <= i_wb.data;
        end
    end
endmodule
`default_nettype wire

// [sad_datapath_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module sad_datapath_tb_top;
    import sad_pkg::*;
    logic     i_core_clk = 1'b0;
    logic     i_rst = 1'b1;
    logic     i_valid = 1'b0;
    logic     i_cond_pass = 1'b0;
    sad_req_s i_req = '0;
    logic     wb_valid, undef, unpred, sat, undef_n;
    sad_wb_s  wb;
    int       n_fail = 0;
    int       n_tests = 0;

    always #5 i_core_clk = ~i_core_clk;

    sad_datapath i_dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_valid(i_valid),
        .i_cond_pass(i_cond_pass), .i_req(i_req), .o_wb_valid(wb_valid), .o_wb(wb),
        .o_undefined(undef), .o_unpredictable(unpred), .o_sat_flag(sat));
    // second copy built without the extension, fed the same issue stream
    sad_datapath #(.EXT_PRESENT(1'b0)) i_dut_noext (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_valid(i_valid), .i_cond_pass(i_cond_pass), .i_req(i_req), .o_wb_valid(),
        .o_wb(), .o_undefined(undef_n), .o_unpredictable(), .o_sat_flag());
    sad_rf_model i_rf (.i_core_clk(i_core_clk), .i_wb_valid(wb_valid), .i_wb(wb));

    task automatic chk(input string what, input logic [31:0] exp, got);
        n_tests++;
        if (exp !== got) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one issue cycle; returns at the falling edge where the answer stands
    task automatic issue(input sad_op_e op, input logic [3:0] d, input logic c,
                         input logic [31:0] a, b);
        @(negedge i_core_clk);
        i_valid = 1'b1;
        i_cond_pass = c;
        i_req = '{op, d, a, b};
        @(negedge i_core_clk);
        i_valid = 1'b0;
        i_cond_pass = 1'b0;
    endtask

    // one instruction, then judge the pulse and the register file entry
    task automatic run(input sad_op_e op, input logic [31:0] a, b, exp, input logic q);
        issue(op, 4'h1, 1'b1, a, b); // destination clear of 13 and 15
        chk("wb_valid", 32'h1, {31'h0, wb_valid});
        chk("wb_dst", 32'h1, {28'h0, wb.dst});
        chk("wb_data", exp, wb.data);
        chk("sat_flag", {31'h0, q}, {31'h0, sat});
        chk("undefined", 32'h1, {31'h0, undef_n});
        chk("ext_undefined", 32'h0, {31'h0, undef});
        chk("unpredictable", 32'h0, {31'h0, unpred});
        @(negedge i_core_clk);
        chk("rf_entry", exp, i_rf.regs_r[1]);
    endtask

    // lane adds saturate per lane and must not touch the flag
    task automatic t_lanes;
        run(SAD_OP_HALF, 32'h0001ffff, 32'h00000001, 32'h00010000, 1'b0);
        run(SAD_OP_HALF, 32'h7fff8000, 32'h0001ffff, 32'h7fff8000, 1'b0);
        run(SAD_OP_BYTE, 32'h7f8001ff, 32'h018001ff, 32'h7f8002fe, 1'b0);
        run(SAD_OP_HALF, 32'h80007fff, 32'hffff0001, 32'h80007fff, 1'b0);
        run(SAD_OP_BYTE, 32'h80ff7f80, 32'hff01ff01, 32'h80007e81, 1'b0);
    endtask

    // word add at both ends of the range, then the flag must stay set
    task automatic t_word;
        run(SAD_OP_WORD, 32'h7ffffffe, 32'h00000001, 32'h7fffffff, 1'b0);
        run(SAD_OP_WORD, 32'h7fffffff, 32'h00000001, 32'h7fffffff, 1'b1);
        run(SAD_OP_WORD, 32'h80000000, 32'hffffffff, 32'h80000000, 1'b1);
        run(SAD_OP_BYTE, 32'h7f7f7f7f, 32'h01010101, 32'h7f7f7f7f, 1'b1);
    endtask

    // refused issues: a failed condition and an unknown op write nothing
    task automatic t_refuse;
        issue(SAD_OP_WORD, 4'h2, 1'b0, 32'h7fffffff, 32'h7fffffff);
        chk("cond_fail_wb", 32'h0, {31'h0, wb_valid});
        chk("cond_fail_flag", 32'h0, {31'h0, sat});
        chk("cond_fail_undef", 32'h0, {31'h0, undef_n});
        issue(sad_op_e'(3'b011), 4'h2, 1'b1, 32'h0, 32'h0);
        chk("bad_op_wb", 32'h0, {31'h0, wb_valid});
    endtask

    // the bench names the stack pointer and program counter on purpose to see unpredictable raised
    task automatic t_bad_dst;
        issue(SAD_OP_HALF, SAD_REG_SP, 1'b1, 32'h0, 32'h0);
        chk("unpred_sp", 32'h1, {31'h0, unpred});
        issue(SAD_OP_BYTE, SAD_REG_PC, 1'b1, 32'h0, 32'h0);
        chk("unpred_pc", 32'h1, {31'h0, unpred});
    endtask

    // reset in mid-run is the only thing that clears the sticky flag
    task automatic t_reset;
        @(negedge i_core_clk);
        i_rst = 1'b1;
        repeat (2) @(negedge i_core_clk);
        i_rst = 1'b0;
        chk("rst_flag", 32'h0, {31'h0, sat});
        chk("rst_wb", 32'h0, {31'h0, wb_valid});
        @(negedge i_core_clk);
        run(SAD_OP_WORD, 32'h00000001, 32'h00000002, 32'h00000003, 1'b0);
    endtask

    task automatic give_verdict;
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(negedge i_core_clk);
        i_rst = 1'b0;
        chk("init_flag", 32'h0, {31'h0, sat});
        t_lanes();
        t_refuse();
        t_word();
        t_bad_dst();
        t_reset();
        give_verdict();
    end

    // watchdog: the whole run needs well under 100 cycles
    initial begin
        #20000;
        n_fail++;
        give_verdict();
    end
endmodule
`default_nettype wire
